// ==== nibble_cpu_pkg.sv ====
/*
  Shared constants, types and decode helpers for the nibble CPU execution core.
  Assumes a single clock domain and an AHB-Lite master for the software view.
*/
package nibble_cpu_pkg;
  localparam int PC_W = 13;
  localparam int WORD_W = 10;
  localparam int DP_W = 10;
  localparam int STACK_DEPTH = 8;
  // Byte addresses of the software-visible registers.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DPTR = 8'h08;
  localparam logic [7:0] REG_ROM_ADDR = 8'h0C;
  localparam logic [7:0] REG_ROM_DATA = 8'h10;
  localparam logic [7:0] REG_RAM_ADDR = 8'h14;
  localparam logic [7:0] REG_RAM_DATA = 8'h18;
  localparam logic [7:0] REG_IRQ_CTL = 8'h1C;
  localparam logic [7:0] REG_TMR_CTL = 8'h20;
  // Control register fields and reset values.
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int POLARITY_BIT = 2;
  localparam int EXT0_EN_BIT = 0;
  localparam int EXT1_EN_BIT = 1;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [2:0] SP_RESET = 3'h7;
  localparam logic [PC_W-1:0] VEC_EXT0 = 13'h0002;
  localparam logic [PC_W-1:0] VEC_EXT1 = 13'h0004;
  // Index of each control register in the control array.
  localparam logic [2:0] CTL_V1 = 3'h0;
  localparam logic [2:0] CTL_V2 = 3'h1;
  localparam logic [2:0] CTL_I1 = 3'h2;
  localparam logic [2:0] CTL_I2 = 3'h3;
  localparam logic [2:0] CTL_W1 = 3'h4;
  localparam logic [2:0] CTL_W2 = 3'h5;
  localparam logic [2:0] CTL_W3 = 3'h6;
  localparam logic [2:0] CTL_W4 = 3'h7;
  // Single opcodes; groups with operand fields are matched on their high bits in the core.
  localparam logic [9:0] OP_AM = 10'h00A, OP_AMC = 10'h00B, OP_AND = 10'h018, OP_OR = 10'h019;
  localparam logic [9:0] OP_SC = 10'h007, OP_RC = 10'h006, OP_SZC = 10'h02F, OP_CMA = 10'h01C;
  localparam logic [9:0] OP_RAR = 10'h01D, OP_SKIP_IF_ACC_EQUALS_MEMORY = 10'h026, OP_SEA = 10'h025;
  localparam logic [9:0] OP_BLA = 10'h010, OP_LONG_CALL_INDIRECT = 10'h030;
  localparam logic [9:0] OP_RTI = 10'h046, OP_RT = 10'h044, OP_RTS = 10'h045;
  localparam logic [9:0] OP_DI = 10'h004, OP_EI = 10'h005, OP_TPAA = 10'h2AA;
  localparam logic [9:0] OP_POLL_EXT0_REQUEST = 10'h038, OP_POLL_EXT1_REQUEST = 10'h039, OP_TEST_EXT0_PIN_LEVEL = 10'h03A, OP_TEST_EXT1_PIN_LEVEL = 10'h03B;
  localparam logic [5:0] HI_LA = 6'h07, HI_ADDI = 6'h06;
  localparam logic [7:0] HI_SB = 8'h17, HI_RB = 8'h13, HI_SZB = 8'h08;
  localparam logic [4:0] HI_BL = 5'h07, HI_BML = 5'h06;
  localparam logic [3:0] HI_ROM_LOOKUP_FETCH = 4'h2;
  localparam logic [2:0] HI_B = 3'h3, HI_BM = 3'h2;
  localparam logic [PC_W-8:0] PAGE_CALL2 = 6'h02;

  typedef enum logic [2:0] {S_EXEC, S_WORD2, S_SKIP2, S_TABP2, S_TABP3, S_RET2} state_t;

  // Address phase captured from the bus.
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } bus_req_t;

  // Context saved at interrupt entry and restored on return_from_irq.
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] b;
    logic [3:0] x;
    logic [3:0] y;
    logic [1:0] z;
    logic cy;
    logic skip;
    logic laChain;
  } ctx_t;

  // Two-word instructions need their second word consumed even when skipped.
  function automatic logic isTwoWord(input logic [9:0] w);
    return (w == OP_SEA) || (w == OP_BLA) || (w == OP_LONG_CALL_INDIRECT) || (w[9:5] == HI_BL) || (w[9:5] == HI_BML);
  endfunction

  // Control register written from the accumulator: {hit, index}.
  function automatic logic [3:0] ctlWrIdx(input logic [9:0] w);
    unique case (w)
      10'h03F: return {1'b1, CTL_V1};
      10'h03E: return {1'b1, CTL_V2};
      10'h217: return {1'b1, CTL_I1};
      10'h218: return {1'b1, CTL_I2};
      10'h20E: return {1'b1, CTL_W1};
      10'h20F: return {1'b1, CTL_W2};
      10'h210: return {1'b1, CTL_W3};
      10'h211: return {1'b1, CTL_W4};
      default: return 4'h0;
    endcase
  endfunction

  // Control register copied into the accumulator: {hit, index}.
  function automatic logic [3:0] ctlRdIdx(input logic [9:0] w);
    unique case (w)
      10'h054: return {1'b1, CTL_V1};
      10'h055: return {1'b1, CTL_V2};
      10'h253: return {1'b1, CTL_I1};
      10'h254: return {1'b1, CTL_I2};
      10'h24B: return {1'b1, CTL_W1};
      10'h24C: return {1'b1, CTL_W2};
      10'h24D: return {1'b1, CTL_W3};
      10'h24E: return {1'b1, CTL_W4};
      default: return 4'h0;
    endcase
  endfunction
endpackage

// ==== nibble_cpu_exec_subset.sv ====
/*
  Nibble CPU execution core with program ROM, data RAM and control registers, loaded and
  observed by software over an AHB-Lite slave port. Assumes one clock and a zero-wait master.
*/
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module nibble_cpu_exec_subset
  import nibble_cpu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic extIrqPin0,
  input wire logic extIrqPin1
);
  logic [WORD_W-1:0] rom [2**PC_W];
  logic [3:0] ram [2**DP_W];
  logic [PC_W-1:0] stk [STACK_DEPTH];
  logic [3:0] ctlQ [8];
  logic paQ;
  logic [PC_W-1:0] pcQ;
  logic [3:0] accQ, bQ, xQ, yQ;
  logic [2:0] dQ, spQ;
  logic [1:0] zQ;
  logic cyQ, inteQ, skipQ, laQ, runQ;
  logic [9:0] firstQ;
  ctx_t ctxQ;
  state_t stateQ;
  bus_req_t bphQ;
  logic [PC_W-1:0] romAddrQ;
  logic [DP_W-1:0] ramAddrQ;
  logic [1:0] pinMeta, pinSync, pinLast;
  logic req0Q, req1Q;
  logic [9:0] instr, tabW;
  logic [3:0] mem;
  logic [4:0] addSum;
  logic boundary, irqTake, laSkip, skipNow, doExec, word2;
  logic clr0, clr1, set0, set1, pushEn, busWr;
  logic [PC_W-1:0] pushVal, pcInc;
  logic [3:0] wrHit, rdHit;

  // Fetch and operand paths are combinational reads of the local arrays.
  assign instr = rom[pcQ];
  assign tabW = rom[{instr[5:0], dQ, accQ}];
  assign mem = ram[{zQ, xQ, yQ}];
  assign pcInc = pcQ + 13'h0001;
  assign addSum = {1'b0, accQ} + {1'b0, instr[3:0]};
  assign wrHit = ctlWrIdx(instr);
  assign rdHit = ctlRdIdx(instr);

  // Interrupts are only taken between whole instructions, never inside a two-word one.
  assign boundary = runQ && (stateQ == S_EXEC);
  assign irqTake = boundary && inteQ && ((req0Q && ctlQ[CTL_V1][EXT0_EN_BIT]) ||
                                         (req1Q && ctlQ[CTL_V1][EXT1_EN_BIT]));
  assign laSkip = laQ && (instr[9:4] == HI_LA);
  assign skipNow = skipQ || laSkip;
  assign doExec = boundary && !irqTake && !skipNow;
  assign word2 = runQ && (stateQ == S_WORD2);

  // Return stack pushes: calls save the next address, interrupts the interrupted one.
  assign pushEn = irqTake || (doExec && ((instr[9:7] == HI_BM) || (instr[9:6] == HI_ROM_LOOKUP_FETCH))) ||
                  (word2 && ((firstQ[9:5] == HI_BML) || (firstQ == OP_LONG_CALL_INDIRECT)));
  assign pushVal = irqTake ? pcQ : pcInc;

  // Request flags are cleared by a taken poll or by interrupt entry.
  assign clr0 = (doExec && instr == OP_POLL_EXT0_REQUEST && !ctlQ[CTL_V1][EXT0_EN_BIT]) ||
                (irqTake && req0Q && ctlQ[CTL_V1][EXT0_EN_BIT]);
  assign clr1 = (doExec && instr == OP_POLL_EXT1_REQUEST && !ctlQ[CTL_V1][EXT1_EN_BIT]) ||
                (irqTake && !(req0Q && ctlQ[CTL_V1][EXT0_EN_BIT]));
  assign set0 = (pinSync[0] != pinLast[0]) && (pinSync[0] == ctlQ[CTL_I1][POLARITY_BIT]);
  assign set1 = (pinSync[1] != pinLast[1]) && (pinSync[1] == ctlQ[CTL_I2][POLARITY_BIT]);
  assign busWr = bphQ.valid && bphQ.write;

  // Two-stage synchroniser for the external request pins, then an edge history stage.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinMeta <= 2'h0;
      pinSync <= 2'h0;
      pinLast <= 2'h0;
    end else begin
      pinMeta <= {extIrqPin1, extIrqPin0};
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  // An edge in the active direction sets the flag; a set in the clearing cycle wins.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req0Q <= 1'b0;
      req1Q <= 1'b0;
    end else begin
      req0Q <= set0 || (req0Q && !clr0);
      req1Q <= set1 || (req1Q && !clr1);
    end
  end

  // AHB-Lite slave: zero wait, always OKAY, read data registered at the address phase.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bphQ <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      bphQ <= '{addr: haddr[7:0], write: hwrite, valid: hsel && htrans[1] && hready};
      if (hsel && htrans[1] && hready && !hwrite) begin
        unique case (haddr[7:0])
          REG_CTRL: hrdata <= {31'h0000_0000, runQ};
          REG_STATUS: hrdata <= {req1Q, req0Q, skipQ, inteQ, spQ, cyQ, dQ, bQ, accQ, pcQ};
          REG_DPTR: hrdata <= {22'h00_0000, zQ, xQ, yQ};
          REG_ROM_ADDR: hrdata <= {19'h0_0000, romAddrQ};
          REG_ROM_DATA: hrdata <= {22'h00_0000, rom[romAddrQ]};
          REG_RAM_ADDR: hrdata <= {22'h00_0000, ramAddrQ};
          REG_RAM_DATA: hrdata <= {28'h000_0000, ram[ramAddrQ]};
          REG_IRQ_CTL: hrdata <= {16'h0000, ctlQ[CTL_I2], ctlQ[CTL_I1], ctlQ[CTL_V2], ctlQ[CTL_V1]};
          REG_TMR_CTL: hrdata <= {15'h0000, paQ, ctlQ[CTL_W4], ctlQ[CTL_W3], ctlQ[CTL_W2], ctlQ[CTL_W1]};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software configuration: run control and the load address pointers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      runQ <= 1'b0;
      romAddrQ <= PC_RESET;
      ramAddrQ <= 10'h000;
    end else if (busWr) begin
      if (bphQ.addr == REG_CTRL) runQ <= hwdata[CTRL_RUN_BIT];
      if (bphQ.addr == REG_ROM_ADDR) romAddrQ <= hwdata[PC_W-1:0];
      if (bphQ.addr == REG_ROM_DATA) romAddrQ <= romAddrQ + 13'h0001;
      if (bphQ.addr == REG_RAM_ADDR) ramAddrQ <= hwdata[DP_W-1:0];
    end
  end

  // Program store; software may load it at any time, so load while halted.
  always_ff @(posedge mclk) begin
    if (busWr && bphQ.addr == REG_ROM_DATA) rom[romAddrQ] <= hwdata[WORD_W-1:0];
  end

  // Data RAM: the core's bit writes take priority over a software write.
  always_ff @(posedge mclk) begin
    if (doExec && (instr[9:2] == HI_SB)) begin
      ram[{zQ, xQ, yQ}] <= mem | (4'h1 << instr[1:0]);
    end else if (doExec && (instr[9:2] == HI_RB)) begin
      ram[{zQ, xQ, yQ}] <= mem & ~(4'h1 << instr[1:0]);
    end else if (busWr && bphQ.addr == REG_RAM_DATA) begin
      ram[ramAddrQ] <= hwdata[3:0];
    end
  end

  // Return stack storage; the pointer lives with the core state.
  always_ff @(posedge mclk) begin
    if (pushEn) stk[spQ + 3'h1] <= pushVal;
  end

  // Interrupt, pin and timer control registers written from the accumulator.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) ctlQ[i] <= 4'h0;
      paQ <= 1'b0;
    end else if (doExec) begin
      if (wrHit[3]) ctlQ[wrHit[2:0]] <= accQ;
      if (instr == OP_TPAA) paQ <= accQ[0];
    end
  end

  // Core sequencer: fetch, skip handling and execution of every instruction except the RAM bit writes and the control register writes.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pcQ <= PC_RESET;
      accQ <= 4'h0;
      bQ <= 4'h0;
      dQ <= 3'h0;
      xQ <= 4'h0;
      yQ <= 4'h0;
      zQ <= 2'h0;
      cyQ <= 1'b0;
      spQ <= SP_RESET;
      inteQ <= 1'b0;
      skipQ <= 1'b0;
      laQ <= 1'b0;
      firstQ <= 10'h000;
      ctxQ <= '0;
      stateQ <= S_EXEC;
    end else if (busWr && bphQ.addr == REG_CTRL && hwdata[CTRL_RESTART_BIT]) begin
      pcQ <= PC_RESET;
      spQ <= SP_RESET;
      skipQ <= 1'b0;
      laQ <= 1'b0;
      stateQ <= S_EXEC;
    end else if (busWr && bphQ.addr == REG_DPTR) begin
      {zQ, xQ, yQ} <= hwdata[DP_W-1:0];
    end else if (runQ) begin
      unique case (stateQ)
        S_EXEC: begin
          if (irqTake) begin
            spQ <= spQ + 3'h1;
            ctxQ <= '{acc: accQ, b: bQ, x: xQ, y: yQ, z: zQ, cy: cyQ, skip: skipQ, laChain: laQ};
            pcQ <= (req0Q && ctlQ[CTL_V1][EXT0_EN_BIT]) ? VEC_EXT0 : VEC_EXT1;
            inteQ <= 1'b0;
            skipQ <= 1'b0;
            laQ <= 1'b0;
          end else if (skipNow) begin
            pcQ <= pcInc;
            skipQ <= 1'b0;
            laQ <= (instr[9:4] == HI_LA);
            if (isTwoWord(instr)) stateQ <= S_SKIP2;
          end else begin
            pcQ <= pcInc;
            skipQ <= 1'b0;
            laQ <= 1'b0;
            if (isTwoWord(instr)) begin
              firstQ <= instr;
              stateQ <= S_WORD2;
            end
            if (rdHit[3]) accQ <= ctlQ[rdHit[2:0]];
            if (instr[9:4] == HI_LA) begin
              accQ <= instr[3:0];
              laQ <= 1'b1;
            end else if (instr[9:4] == HI_ADDI) begin
              accQ <= addSum[3:0];
              skipQ <= !addSum[4];
            end else if (instr[9:6] == HI_ROM_LOOKUP_FETCH) begin
              spQ <= spQ + 3'h1;
              dQ <= {1'b0, tabW[9:8]};
              bQ <= tabW[7:4];
              accQ <= tabW[3:0];
              stateQ <= S_TABP2;
            end else if (instr[9:7] == HI_B) begin
              pcQ <= {pcQ[PC_W-1:7], instr[6:0]};
            end else if (instr[9:7] == HI_BM) begin
              spQ <= spQ + 3'h1;
              pcQ <= {PAGE_CALL2, instr[6:0]};
            end else if (instr[9:2] == HI_SZB) begin
              skipQ <= !mem[instr[1:0]];
            end else begin
              unique case (instr)
                OP_AM: accQ <= accQ + mem;
                OP_AMC: {cyQ, accQ} <= {1'b0, accQ} + {1'b0, mem} + {4'h0, cyQ};
                OP_AND: accQ <= accQ & mem;
                OP_OR: accQ <= accQ | mem;
                OP_SC: cyQ <= 1'b1;
                OP_RC: cyQ <= 1'b0;
                OP_SZC: skipQ <= !cyQ;
                OP_CMA: accQ <= ~accQ;
                OP_RAR: {accQ, cyQ} <= {cyQ, accQ};
                OP_SKIP_IF_ACC_EQUALS_MEMORY: skipQ <= (accQ == mem);
                OP_DI: inteQ <= 1'b0;
                OP_EI: inteQ <= 1'b1;
                OP_POLL_EXT0_REQUEST: skipQ <= !ctlQ[CTL_V1][EXT0_EN_BIT] && req0Q;
                OP_POLL_EXT1_REQUEST: skipQ <= !ctlQ[CTL_V1][EXT1_EN_BIT] && req1Q;
                OP_TEST_EXT0_PIN_LEVEL: skipQ <= (pinSync[0] == ctlQ[CTL_I1][POLARITY_BIT]);
                OP_TEST_EXT1_PIN_LEVEL: skipQ <= (pinSync[1] == ctlQ[CTL_I2][POLARITY_BIT]);
                OP_RTI: begin
                  pcQ <= stk[spQ];
                  spQ <= spQ - 3'h1;
                  {accQ, bQ, xQ, yQ, zQ, cyQ} <= {ctxQ.acc, ctxQ.b, ctxQ.x, ctxQ.y, ctxQ.z, ctxQ.cy};
                  skipQ <= ctxQ.skip;
                  laQ <= ctxQ.laChain;
                end
                OP_RT, OP_RTS: begin
                  pcQ <= stk[spQ];
                  spQ <= spQ - 3'h1;
                  skipQ <= (instr == OP_RTS);
                  stateQ <= S_RET2;
                end
                default: ;
              endcase
            end
          end
        end
        S_WORD2: begin
          stateQ <= S_EXEC;
          pcQ <= pcInc;
          if (firstQ == OP_SEA) begin
            skipQ <= (accQ == instr[3:0]);
          end else if (firstQ == OP_BLA || firstQ == OP_LONG_CALL_INDIRECT) begin
            pcQ <= {instr[7:6], instr[3:0], dQ, accQ};
          end else begin
            pcQ <= {instr[7], firstQ[4:0], instr[6:0]};
          end
          if (firstQ[9:5] == HI_BML || firstQ == OP_LONG_CALL_INDIRECT) spQ <= spQ + 3'h1;
        end
        S_SKIP2: begin
          pcQ <= pcInc;
          stateQ <= S_EXEC;
        end
        S_TABP2: stateQ <= S_TABP3;
        S_TABP3: begin
          spQ <= spQ - 3'h1;
          stateQ <= S_EXEC;
        end
        S_RET2: stateQ <= S_EXEC;
      endcase
    end
  end

  // Checks on the execution core.
  property p_carry_set;
    @(posedge mclk) disable iff (rst) doExec && instr == OP_SC |=> cyQ && $stable(accQ);
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("set_carry did not set carry");

  property p_invert;
    @(posedge mclk) disable iff (rst) doExec && instr == OP_CMA |=> accQ == ~$past(accQ) && $stable(cyQ);
  endproperty
  a_invert: assert property (p_invert) else $error("invert_acc result wrong");

  property p_rotate;
    @(posedge mclk) disable iff (rst)
      doExec && instr == OP_RAR |=> cyQ == $past(accQ[0]) && accQ == {$past(cyQ), $past(accQ[3:1])};
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate through carry wrong");

  property p_addi_skip;
    @(posedge mclk) disable iff (rst) doExec && instr[9:4] == HI_ADDI |=> skipQ == !$past(addSum[4]);
  endproperty
  a_addi_skip: assert property (p_addi_skip) else $error("add immediate skip wrong");

  property p_short_branch;
    @(posedge mclk) disable iff (rst)
      doExec && instr[9:7] == HI_B |=> pcQ == {$past(pcQ[PC_W-1:7]), $past(instr[6:0])};
  endproperty
  a_short_branch: assert property (p_short_branch) else $error("short branch left its region");

  property p_ret_two;
    @(posedge mclk) disable iff (rst) doExec && instr == OP_RT |=> stateQ == S_RET2 ##1 stateQ == S_EXEC;
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("plain return not two cycles");

  property p_di;
    @(posedge mclk) disable iff (rst) doExec && instr == OP_DI |=> !inteQ;
  endproperty
  a_di: assert property (p_di) else $error("mask-all left enable set");

  property p_la_chain;
    @(posedge mclk) disable iff (rst)
      doExec && instr[9:4] == HI_LA ##1 boundary && !irqTake && instr[9:4] == HI_LA |=> $stable(accQ);
  endproperty
  a_la_chain: assert property (p_la_chain) else $error("chained load executed");

  property p_skip_inert;
    @(posedge mclk) disable iff (rst) boundary && !irqTake && skipQ |=> $stable(accQ) && $stable(cyQ) && $stable(inteQ);
  endproperty
  a_skip_inert: assert property (p_skip_inert) else $error("skipped instruction changed state");

  c_rom_lookup_fetch: cover property (@(posedge mclk) disable iff (rst) stateQ == S_TABP2 ##1 stateQ == S_TABP3);
  c_irq: cover property (@(posedge mclk) disable iff (rst) irqTake);
  c_rti: cover property (@(posedge mclk) disable iff (rst) doExec && instr == OP_RTI);
  c_skip2: cover property (@(posedge mclk) disable iff (rst) stateQ == S_SKIP2);
endmodule

// ==== ext_pin_source.sv ====
/*
  Stand-in for the two external request sources wired to the core's request pins.
  Assumes the bench sets the wanted levels; the pins move only just after a rising edge.
*/
`timescale 1ns/1ps
module ext_pin_source (
  input wire logic mclk,
  input wire logic [1:0] level,
  output logic extIrqPin0,
  output logic extIrqPin1
);
  // Both pins start low so that no edge is seen while the core leaves reset.
  initial begin
    extIrqPin0 = 1'b0;
    extIrqPin1 = 1'b0;
  end

  // Registering the levels keeps pin edges clear of the core's sampling edge.
  always @(posedge mclk) begin
    extIrqPin0 <= level[0];
    extIrqPin1 <= level[1];
  end
endmodule

// ==== testbench.sv ====
/*
  Self-checking bench for the nibble CPU core: loads small programs over AHB-Lite, runs them
  and compares the visible state. Assumes a zero-wait slave whose hreadyout is the bus hready.
*/
`timescale 1ns/1ps
module testbench;
  import nibble_cpu_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] st;
  logic [1:0] htrans = 2'h0;
  logic [1:0] level = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready;
  logic hresp;
  logic extIrqPin0;
  logic extIrqPin1;
  logic [9:0] prog[$];
  int n_mismatch = 0;
  int cmp_count = 0;

  // Free-running 25 MHz clock.
  always #20 mclk = ~mclk;

  nibble_cpu_exec_subset nibble_cpu_exec_subset_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .extIrqPin0(extIrqPin0), .extIrqPin1(extIrqPin1));
  ext_pin_source ext_pin_source_i (.mclk(mclk), .level(level), .extIrqPin0(extIrqPin0), .extIrqPin1(extIrqPin1));

  // One single word transfer; the leading edge leaves an idle cycle after any earlier data phase.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    st = hrdata;
  endtask

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Writes the queued words into program memory from the given address on.
  task automatic load(input logic [12:0] base);
    xfer(REG_ROM_ADDR, 1'b1, {19'h0, base});
    foreach (prog[i]) xfer(REG_ROM_DATA, 1'b1, {22'h0, prog[i]});
  endtask

  // Polls the status word until the core parks at its final loop, bounded so a hang shows.
  task automatic runTo(input logic [12:0] pc);
    st = 32'hFFFFFFFF;
    for (int i = 0; i < 40 && st[12:0] !== pc; i++) xfer(REG_STATUS, 1'b0, 32'h0);
    chk("pc", st[12:0], pc);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence: arithmetic, skips and flow control first, then pin tests and polling.
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    xfer(REG_RAM_ADDR, 1'b1, 32'h0);
    xfer(REG_RAM_DATA, 1'b1, 32'h6);
    xfer(REG_DPTR, 1'b1, 32'h0);
    prog = '{10'h075, 10'h079, 10'h063, 10'h071, 10'h007, 10'h00A, 10'h01D, 10'h02F, 10'h007, 10'h01C,
      10'h00B, 10'h026, 10'h07F, 10'h05F, 10'h020, 10'h019, 10'h04E, 10'h025, 10'h076, 10'h0E0, 10'h27F,
      10'h110, 10'h071, 10'h005, 10'h20E, 10'h0E0, 10'h240};
    load(13'h0);
    prog = '{10'h045};
    load(13'h110);
    prog = '{10'h1C0};
    load(13'h040);
    xfer(REG_CTRL, 1'b1, 32'h3);
    runTo(13'h040);
    chk("acc", st[16:13], 4'h6);
    chk("carry", st[24], 1'b0);
    chk("sp", st[27:25], 3'h7);
    chk("enable", st[28], 1'b1);
    xfer(REG_RAM_DATA, 1'b0, 32'h0);
    chk("ram", st, 32'hA);
    xfer(REG_TMR_CTL, 1'b0, 32'h0);
    chk("timer", st, 32'h6);
    $display("Test of arithmetic and flow control done");
    xfer(REG_CTRL, 1'b1, 32'h0);
    level <= 2'h1;
    prog = '{10'h004, 10'h074, 10'h217, 10'h03A, 10'h007, 10'h03B, 10'h20F, 10'h038, 10'h187, 10'h079,
      10'h2AA, 10'h18B};
    load(13'h0);
    xfer(REG_CTRL, 1'b1, 32'h3);
    repeat (20) @(posedge mclk);
    xfer(REG_STATUS, 1'b0, 32'h0);
    chk("waiting", st[12:0] == 13'h00B, 1'b0);
    level <= 2'h0;
    repeat (8) @(posedge mclk);
    level <= 2'h1;
    runTo(13'h00B);
    chk("acc", st[16:13], 4'h9);
    chk("carry", st[24], 1'b0);
    chk("enable", st[28], 1'b0);
    chk("request", st[30], 1'b0);
    xfer(REG_TMR_CTL, 1'b0, 32'h0);
    chk("timer", st, 32'h10006);
    xfer(REG_IRQ_CTL, 1'b0, 32'h0);
    chk("irqctl", st, 32'h400);
    xfer(8'h30, 1'b0, 32'h0);
    chk("unmapped", st, 32'h0);
    chk("hresp", hresp, 1'b0);
    $display("Test of pin tests and request polling done");
    wrap_up();
  end

  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
